// ===== hdl/mdac_dev_end.sv
`timescale 1ns/100ps
module mdac_dev_end (
    input wire logic sys_clk,
    input wire logic rst,
    mdac_if.device link,
    input wire logic converterEnableBit,
    input wire logic [1:0] rateSel,
    input wire logic chanSel,
    input wire logic overCurrentIn,
    input wire logic analogClipIn,
    output logic convOutPos,
    output logic convOutNeg,
    output logic clipOut,
    output logic slaveAddrLsb,
    output logic fullBand
);
    import mdac_pkg::*;

    // ****************************************
    // State of the control side
    // ****************************************
    typedef struct packed {
        logic en;
        logic [1:0] rate;
        logic chan;
        logic clipMeta;
        logic clipSync;
        logic ocMeta;
        logic oc;
        logic acMeta;
        logic ac;
        logic addrMeta;
        logic addrLvl;
        logic clip;
        logic faultDrv;
        logic faultOe;
        logic addrLsb;
        logic full;
    } mdac_sys_t;

    // ****************************************
    // State of the bit clock side
    // ****************************************
    typedef struct packed {
        logic rstMeta;
        logic rstSync;
        logic enMeta;
        logic en;
        logic [1:0] rateMeta;
        logic [1:0] rateSync;
        logic [1:0] rateLast;
        logic [1:0] rate;
        logic chanMeta;
        logic chan;
        logic wsDly;
        logic slotWs;
        logic [5:0] bitCnt;
        logic [17:0] shift;
        logic newSample;
        logic [17:0] filt;
        logic [3:0] pwmCnt;
        logic [3:0] coarse;
        logic [3:0] fine;
        logic pos;
        logic neg;
        logic clip;
    } mdac_link_t;

    mdac_sys_t s;
    mdac_sys_t next_s;
    mdac_link_t l;
    mdac_link_t next_l;

    logic signed [18:0] diff;
    logic signed [18:0] step;
    logic [17:0] uOff;

    // ****************************************
    // Control side, on sys_clk
    // ****************************************
    always_comb begin
        next_s = s;
        next_s.en = converterEnableBit;
        next_s.rate = rateSel;
        next_s.chan = chanSel;
        // Clip level from the bit clock side
        next_s.clipMeta = l.clip;
        next_s.clipSync = s.clipMeta;
        next_s.ocMeta = overCurrentIn;
        next_s.oc = s.ocMeta;
        next_s.acMeta = analogClipIn;
        next_s.ac = s.acMeta;
        next_s.addrMeta = link.faultLevel;
        next_s.addrLvl = s.addrMeta;
        // Any of the three sources counts as clipping
        next_s.clip = s.clipSync | s.oc | s.ac;
        next_s.faultDrv = 1'b0;
        // Pin pulled low while clipping, only with converter on
        next_s.faultOe = s.en & s.clip;
        // Strap ignored while converter on
        next_s.addrLsb = s.en ? 1'b0 : s.addrLvl;
        next_s.full = s.en & s.rate[1];
        if (rst) begin
            next_s = '0;
            next_s.en = ENABLE_RST;
            next_s.rate = RATIO_RST;
            next_s.chan = CHAN_LEFT;
        end
    end

    always_ff @(posedge sys_clk) begin
        s <= next_s;
    end

    // ****************************************
    // Converter datapath
    // ****************************************
    // Offset binary view of the filtered sample
    assign uOff = {~l.filt[17], l.filt[16:0]};
    assign diff = $signed({l.shift[17], l.shift}) - $signed({l.filt[17], l.filt});
    assign step = diff >>> BASS_SHIFT;

    // ****************************************
    // Bit clock side, on link.bclk
    // ****************************************
    // Everything here stops with the bit clock: no PLL clock, no conversion
    always_comb begin
        next_l = l;
        next_l.rstMeta = rst;
        next_l.rstSync = l.rstMeta;
        // Settings are quasi static; a change may glitch one sample
        next_l.enMeta = s.en;
        next_l.en = l.enMeta;
        next_l.rateMeta = s.rate;
        next_l.rateSync = l.rateMeta;
        next_l.rateLast = l.rateSync;
        // Two bit word: take it only when two samples agree, so bit skew never shows
        if (l.rateSync == l.rateLast) begin
            next_l.rate = l.rateSync;
        end
        next_l.chanMeta = s.chan;
        next_l.chan = l.chanMeta;
        next_l.wsDly = link.ws;
        next_l.newSample = 1'b0;

        // Slot counting from each word select edge
        if (link.ws != l.wsDly) begin
            next_l.bitCnt = 6'h00;
            next_l.slotWs = link.ws;
        end else if (l.bitCnt != SLOT_BITS) begin
            next_l.bitCnt = l.bitCnt + 6'h01;
        end

        // MSB arrives one bit after the edge; the tail is dropped
        if (link.ws == l.wsDly && l.bitCnt < SAMPLE_BITS) begin
            next_l.shift = {l.shift[16:0], link.sd};
            if (l.bitCnt == SAMPLE_LAST && l.slotWs == l.chan) begin
                next_l.newSample = 1'b1;
            end
        end

        // Bass mode smooths; full band trusts sender interpolation
        if (l.newSample) begin
            case (l.rate)
                RATIO_BASS_A, RATIO_BASS_B: begin
                    next_l.filt = l.filt + step[17:0];
                end
                RATIO_FULL_96, RATIO_FULL_192: begin
                    next_l.filt = l.shift;
                end
                default: begin
                    next_l.filt = l.shift;
                end
            endcase
        end

        // Coarse and fine waves; fine weighted 1/16 off chip
        next_l.pwmCnt = l.pwmCnt + 4'h1;
        if (l.pwmCnt == PWM_LAST) begin
            next_l.coarse = uOff[17:14];
            next_l.fine = ~uOff[13:10];
        end
        next_l.pos = l.en & (l.pwmCnt < l.coarse);
        next_l.neg = l.en & (l.pwmCnt < l.fine);

        // Full scale sample means maximum modulation
        next_l.clip = l.en & (uOff[17:10] == CLIP_TOP || uOff[17:10] == CLIP_BOTTOM);

        if (l.rstSync) begin
            next_l = '0;
            next_l.rstMeta = rst;
            next_l.rstSync = l.rstMeta;
        end
    end

    always_ff @(posedge link.bclk) begin
        l <= next_l;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign convOutPos = l.pos;
    assign convOutNeg = l.neg;
    // Clip output exists whatever the mode
    assign clipOut = s.clip;
    assign slaveAddrLsb = s.addrLsb;
    assign fullBand = s.full;
    assign link.faultOut = s.faultDrv;
    assign link.faultOe = s.faultOe;
endmodule

// ===== hdl/mdac_host_end.sv
`timescale 1ns/100ps
module mdac_host_end #(
    parameter int HALF_DIV = mdac_pkg::HOST_HALF_DIV
) (
    input wire logic sys_clk,
    input wire logic rst,
    mdac_if.host link,
    input wire logic [31:0] leftWord,
    input wire logic [31:0] rightWord,
    input wire logic wordValid,
    output logic wordReady,
    output logic clipSeen
);
    import mdac_pkg::*;

    // ****************************************
    // Sender state
    // ****************************************
    typedef struct packed {
        logic [7:0] divCnt;
        logic bclk;
        logic ws;
        logic sd;
        logic [5:0] pos;
        logic [63:0] frame;
        logic ready;
        logic clipMeta;
        logic clipSync;
    } mdac_host_t;

    mdac_host_t h;
    mdac_host_t next_h;

    // ****************************************
    // Bit clock divider and framing
    // ****************************************
    // Words handed in are expected already interpolated
    always_comb begin
        next_h = h;
        next_h.ready = 1'b0;
        next_h.clipMeta = link.faultLevel;
        // Held inverted so the output leaves a flop directly
        next_h.clipSync = ~h.clipMeta;
        if (h.divCnt == 8'(HALF_DIV - 1)) begin
            next_h.divCnt = 8'h00;
            next_h.bclk = ~h.bclk;
            // Data and word select change on the falling edge
            if (h.bclk) begin
                next_h.pos = h.pos + 6'h01;
                if (h.pos == FRAME_LAST) begin
                    // No word ready: send silence
                    next_h.frame = wordValid ? {leftWord, rightWord} : 64'h0;
                    next_h.ready = wordValid;
                end else begin
                    next_h.frame = {h.frame[62:0], 1'b0};
                end
                next_h.sd = next_h.frame[63];
                // Word select leads each slot by one bit
                next_h.ws = (next_h.pos >= RIGHT_WS_POS) && (next_h.pos != FRAME_LAST);
            end
        end else begin
            next_h.divCnt = h.divCnt + 8'h01;
        end
        if (rst) begin
            next_h = '0;
            next_h.pos = FRAME_LAST - 6'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        h <= next_h;
    end

    assign link.bclk = h.bclk;
    assign link.ws = h.ws;
    assign link.sd = h.sd;
    assign wordReady = h.ready;
    // Pin low means clipping
    assign clipSeen = h.clipSync;
endmodule

// ===== hdl/mdac_if.sv
`timescale 1ns/100ps
interface mdac_if;
    logic bclk;
    logic ws;
    logic sd;
    logic faultOut;
    logic faultOe;
    wire logic faultLevel;

    // Open drain with pull-up
    assign faultLevel = faultOe ? faultOut : 1'b1;

    modport host (
        output bclk,
        output ws,
        output sd,
        input faultLevel
    );
    modport device (
        input bclk,
        input ws,
        input sd,
        input faultLevel,
        output faultOut,
        output faultOe
    );
endinterface

// ===== hdl/mdac_pkg.sv
// Overview of operation
// - Converter off until enable bit set
// - Ratio 00/01: bass only, 48 kHz
// - Ratio 10: full band 96 kHz, sender x2
// - Ratio 11: full band 192 kHz, sender x4
// - Sender stage one: 57-tap half-band filter
// - Stage one: 15 coefficients, centre 2047
// - Stage two: 7 taps, -190, 1199, 2047
// - Stage costs: 28/14/14, then 4/2/2
// - Word select toggles at Fs, names channel
// - Bit clock is 64 times sample rate
// - 32-bit slots, only first 18 used
// - Convert only the selected channel
// - Converter clocked from the bit clock
// - Outputs: two PWM waves, 16:1 weight
// - Converter on: fault pin shows clipping
// - Converter on: address low bit forced zero
// - Clip indication present in every mode
// - Clip on max modulation, overcurrent, analog clip
package mdac_pkg;
    // ****************************************
    // Link framing
    // ****************************************
    localparam int BCLK_PER_FS = 64;
    localparam logic [5:0] SLOT_BITS = 6'h20;
    localparam logic [5:0] SAMPLE_BITS = 6'h12;
    localparam logic [5:0] SAMPLE_LAST = 6'h11;
    localparam logic [5:0] FRAME_LAST = 6'h3f;
    localparam logic [5:0] RIGHT_WS_POS = 6'h1f;
    localparam logic CHAN_LEFT = 1'b0;
    // ****************************************
    // Rate ratio codes and rates in kHz
    // ****************************************
    localparam logic [1:0] RATIO_BASS_A = 2'h0;
    localparam logic [1:0] RATIO_BASS_B = 2'h1;
    localparam logic [1:0] RATIO_FULL_96 = 2'h2;
    localparam logic [1:0] RATIO_FULL_192 = 2'h3;
    localparam int RATE_BASS_KHZ = 48;
    localparam int RATE_FULL_A_KHZ = 96;
    localparam int RATE_FULL_B_KHZ = 192;
    // ****************************************
    // Converter
    // ****************************************
    localparam logic [3:0] PWM_LAST = 4'hf;
    localparam int FINE_WEIGHT = 16;
    localparam int BASS_SHIFT = 2;
    localparam logic [7:0] CLIP_TOP = 8'hff;
    localparam logic [7:0] CLIP_BOTTOM = 8'h00;
    // ****************************************
    // Reset values and host clock divider
    // ****************************************
    localparam logic ENABLE_RST = 1'b0;
    localparam logic [1:0] RATIO_RST = 2'h0;
    localparam int HOST_HALF_DIV = 3;
endpackage

// ===== tb/mdac_link_monitor.sv
`timescale 1ns/100ps
module mdac_link_monitor #(
    parameter int HALF_DIV = mdac_pkg::HOST_HALF_DIV
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic bclk,
    input wire logic ws,
    input wire logic sd,
    input wire logic faultOut,
    input wire logic faultOe,
    input wire logic faultLevel
);
    import mdac_pkg::*;
    // ****************************************
    // Helper counters
    // ****************************************
    // No bclk edges in reset, so first slot is skipped by wsSeen
    logic [5:0] slotCnt;
    logic wsPrev;
    logic wsSeen;
    logic [7:0] runCnt;
    logic bclkPrev;
    logic bclkSeen;
    always_ff @(posedge bclk) begin
        wsPrev <= ws;
        if (rst) begin
            slotCnt <= 6'h00;
            wsSeen <= 1'b0;
        end else if (ws != wsPrev) begin
            slotCnt <= 6'h00;
            wsSeen <= 1'b1;
        end else begin
            slotCnt <= slotCnt + 6'h01;
        end
    end
    always_ff @(posedge sys_clk) begin
        bclkPrev <= bclk;
        if (rst) begin
            runCnt <= 8'h00;
            bclkSeen <= 1'b0;
        end else if (bclk != bclkPrev) begin
            runCnt <= 8'h00;
            bclkSeen <= 1'b1;
        end else begin
            runCnt <= runCnt + 8'h01;
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    property p_wsSlot;
        @(posedge bclk) disable iff (rst) (wsSeen && ws != wsPrev) |-> slotCnt == 6'h1f;
    endproperty
    property p_wsBound;
        @(posedge bclk) disable iff (rst) wsSeen |-> slotCnt <= 6'h1f;
    endproperty
    property p_highPhase;
        @(posedge sys_clk) disable iff (rst)
            (bclkSeen && bclkPrev && !bclk) |-> runCnt == 8'(HALF_DIV - 1);
    endproperty
    property p_lowPhase;
        @(posedge sys_clk) disable iff (rst)
            (bclkSeen && !bclkPrev && bclk) |-> runCnt == 8'(HALF_DIV - 1);
    endproperty
    property p_bclkRun;
        @(posedge sys_clk) disable iff (rst) bclkSeen |-> runCnt < 8'(HALF_DIV);
    endproperty
    property p_dataOnFall;
        @(posedge sys_clk) disable iff (rst) ($changed(sd) || $changed(ws)) |-> !bclk;
    endproperty
    property p_drivesLow;
        @(posedge sys_clk) disable iff (rst) faultOe |-> (!faultOut && !faultLevel);
    endproperty
    property p_idleHigh;
        @(posedge sys_clk) disable iff (rst) !faultOe |-> faultLevel;
    endproperty
    a_wsSlot: assert property (p_wsSlot) else $error("ws slot not 32 bits");
    a_wsBound: assert property (p_wsBound) else $error("ws stuck");
    a_highPhase: assert property (p_highPhase) else $error("bclk high phase");
    a_lowPhase: assert property (p_lowPhase) else $error("bclk low phase");
    a_bclkRun: assert property (p_bclkRun) else $error("bclk stopped");
    a_dataOnFall: assert property (p_dataOnFall) else $error("data moved in high");
    a_drivesLow: assert property (p_drivesLow) else $error("fault pin not low");
    a_idleHigh: assert property (p_idleHigh) else $error("fault pin idle low");
    c_wsToggle: cover property (@(posedge bclk) wsSeen && ws != wsPrev);
    c_faultOn: cover property (@(posedge sys_clk) $rose(faultOe));
    c_faultOff: cover property (@(posedge sys_clk) $fell(faultOe));
endmodule

// ===== tb/mono_audio_dac_serial_input_test.sv
`timescale 1ns/100ps
module mono_audio_dac_serial_input_test;
    import mdac_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic devRst = 1'b1;
    logic converterEnableBit = 1'b0;
    logic [1:0] rateSel = 2'h0;
    logic chanSel = 1'b0;
    logic overCurrentIn = 1'b0;
    logic analogClipIn = 1'b0;
    logic [31:0] leftWord = 32'h0;
    logic [31:0] rightWord = 32'h0;
    logic wordValid = 1'b0;
    logic convOutPos, convOutNeg, clipOut, slaveAddrLsb, fullBand, wordReady, clipSeen;
    logic [15:0] pos, neg, rdy;
    int failures = 0;
    int check_count = 0;
    mdac_if link ();
    mdac_host_end mdac_host_end_inst (.sys_clk(sys_clk), .rst(rst), .link(link.host),
        .leftWord(leftWord), .rightWord(rightWord), .wordValid(wordValid),
        .wordReady(wordReady), .clipSeen(clipSeen));
    mdac_dev_end mdac_dev_end_inst (.sys_clk(sys_clk), .rst(devRst), .link(link.device),
        .converterEnableBit(converterEnableBit), .rateSel(rateSel), .chanSel(chanSel),
        .overCurrentIn(overCurrentIn), .analogClipIn(analogClipIn), .convOutPos(convOutPos),
        .convOutNeg(convOutNeg), .clipOut(clipOut), .slaveAddrLsb(slaveAddrLsb),
        .fullBand(fullBand));
    mdac_link_monitor mdac_link_monitor_inst (.sys_clk(sys_clk), .rst(rst), .bclk(link.bclk),
        .ws(link.ws), .sd(link.sd), .faultOut(link.faultOut), .faultOe(link.faultOe),
        .faultLevel(link.faultLevel));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        check_count++;
        if (seen !== expected) begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic end_of_test();
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Bound covers frame, filter and PWM period latency
    task automatic wait_clip(input logic want);
        int i;
        for (i = 0; i < 2000 && clipSeen !== want; i++) begin
            @(negedge sys_clk);
        end
        check(16'(clipSeen), 16'(want));
        if (clipSeen !== want) begin
            end_of_test();
        end
    endtask
    // 384 sys cycles is exactly 64 bclk, four PWM periods: 24 per duty step
    task automatic duty();
        pos = 16'h0;
        neg = 16'h0;
        rdy = 16'h0;
        repeat (384) begin
            @(negedge sys_clk);
            pos = pos + 16'(convOutPos);
            neg = neg + 16'(convOutNeg);
            rdy = rdy + 16'(wordReady);
        end
        check(rdy, 16'h1);
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        // Device held longer so its bclk side sees reset
        repeat (60) @(posedge sys_clk);
        devRst <= 1'b0;
        overCurrentIn <= 1'b1;
        repeat (100) @(posedge sys_clk);
        @(negedge sys_clk);
        check(16'(convOutPos), 16'h0);
        check(16'(convOutNeg), 16'h0);
        check(16'(clipOut), 16'h1);
        check(16'(clipSeen), 16'h0);
        check(16'(slaveAddrLsb), 16'h1);
        @(posedge sys_clk);
        overCurrentIn <= 1'b0;
        converterEnableBit <= 1'b1;
        wordValid <= 1'b1;
        leftWord <= 32'h2500_3fff;
        rightWord <= 32'hc300_0000;
        for (int r = 0; r < 4; r++) begin
            @(posedge sys_clk);
            rateSel <= 2'(r);
            repeat (100) @(posedge sys_clk);
            @(negedge sys_clk);
            check(16'(fullBand), 16'(r / 2));
            check(16'(slaveAddrLsb), 16'h0);
        end
        repeat (1500) @(posedge sys_clk);
        duty();
        check(pos, 16'd240);
        check(neg, 16'd240);
        @(posedge sys_clk);
        chanSel <= 1'b1;
        repeat (1500) @(posedge sys_clk);
        duty();
        check(pos, 16'd96);
        check(neg, 16'd288);
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            {overCurrentIn, analogClipIn} <= 2'h1 << k;
            wait_clip(1'b1);
            check(16'(clipOut), 16'h1);
            @(posedge sys_clk);
            {overCurrentIn, analogClipIn} <= 2'h0;
            wait_clip(1'b0);
        end
        @(posedge sys_clk);
        rightWord <= 32'h7fff_ffff;
        wait_clip(1'b1);
        @(posedge sys_clk);
        converterEnableBit <= 1'b0;
        wait_clip(1'b0);
        // Enable reaches the bit clock side several bclk later than the pin
        repeat (60) @(posedge sys_clk);
        duty();
        check(pos, 16'h0);
        check(neg, 16'h0);
        end_of_test();
    end
endmodule
